// *** design/i2rg_pkg.sv ***
// Purpose: shared constants and types for the i2c read / general call target
// Assumes: 7-bit target address, 5-bit register address, 16-bit register words
// Notes:   bus pins are sampled by the system clock through two flip-flops
package i2rg_pkg;

   localparam int unsigned ADDR_W     = 5;
   localparam int unsigned DATA_W     = 16;
   localparam int unsigned NUM_REGS   = 32;
   localparam int unsigned NUM_CH     = 2;

   // command byte layout
   localparam int unsigned CMD_ADDR_HI = 7;
   localparam int unsigned CMD_ADDR_LO = 3;
   localparam int unsigned CMD_OP_HI   = 2;
   localparam int unsigned CMD_OP_LO   = 1;
   localparam logic [1:0]  CMD_OP_READ = 2'h3;

   // general call codes and bit counter limits
   localparam logic [7:0] GC_ADDR     = 8'h00;
   localparam logic [7:0] GC_RESET    = 8'h06;
   localparam logic [7:0] GC_WAKE     = 8'h0a;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [2:0] BIT_FIRST   = 3'h0;

   // register map
   localparam logic [ADDR_W-1:0] REG_DAC0  = 5'h00;
   localparam logic [ADDR_W-1:0] REG_DAC1  = 5'h01;
   localparam logic [ADDR_W-1:0] REG_VREF  = 5'h08;
   localparam logic [ADDR_W-1:0] REG_PDN   = 5'h09;
   localparam logic [ADDR_W-1:0] REG_GAIN  = 5'h0a;

   localparam logic [DATA_W-1:0] DAC_DEFAULT = 16'h007f;
   localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000;

   // sampled bus pins
   typedef struct packed {
      logic scl;
      logic sda;
   } i2rg_pins_t;

   // decoded bus conditions, one-cycle pulses
   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
   } i2rg_evt_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_RXBYT = 3'b001,
      ST_ACK   = 3'b010,
      ST_TXBYT = 3'b011,
      ST_MACK  = 3'b100,
      ST_IGN   = 3'b101,
      ST_NAK   = 3'b110
   } i2rg_state_t;

   typedef enum logic [1:0] {
      PH_CTRL = 2'b00,
      PH_CMD  = 2'b01,
      PH_GC   = 2'b10,
      PH_DATA = 2'b11
   } i2rg_phase_t;

endpackage : i2rg_pkg

// *** design/i2rg_sync.sv ***
// Purpose: two-flop synchroniser and start/stop/edge detector for scl and sda
// Assumes: pins are idle high after reset
// Notes:   first flop stages feed only the second stage
`timescale 1ns/1ps
module i2rg_sync
   import i2rg_pkg::*;
(
   input  wire logic      ref_clk_i,
   input  wire logic      resetn_i,
   input  wire logic      clk_en_i,
   input  wire logic      scl_i,
   input  wire logic      sda_i,
   output i2rg_pkg::i2rg_pins_t pins_o,
   output i2rg_pkg::i2rg_evt_t  evt_o
);
   i2rg_pins_t meta;
   i2rg_pins_t sync;
   i2rg_pins_t prev;
   i2rg_pins_t next_meta;
   i2rg_pins_t next_sync;
   i2rg_pins_t next_prev;

   always_comb
   begin
      next_meta = meta;
      next_sync = sync;
      next_prev = prev;
      if (clk_en_i)
      begin
         next_meta = '{scl: scl_i, sda: sda_i};
         next_sync = meta;
         next_prev = sync;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta <= '{scl: 1'b1, sda: 1'b1};
         sync <= '{scl: 1'b1, sda: 1'b1};
         prev <= '{scl: 1'b1, sda: 1'b1};
      end
      else
      begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   assign pins_o         = sync;
   assign evt_o.start    = clk_en_i & prev.scl & sync.scl & prev.sda & ~sync.sda;
   assign evt_o.stop     = clk_en_i & prev.scl & sync.scl & ~prev.sda & sync.sda;
   assign evt_o.scl_rise = clk_en_i & ~prev.scl & sync.scl;
   assign evt_o.scl_fall = clk_en_i & prev.scl & ~sync.scl;

endmodule : i2rg_sync

// *** design/i2rg_target.sv ***
// Purpose: i2c target for reads and general call reset / wake-up
// Assumes: host drives scl; ref_clk_i far faster than scl
// Notes:   register writes are outside this block and appear on wr_* inputs
// Behaviour
// (RQ1) undefined command: release sda, ignore bus until new start and control byte
// (RQ2) capture addressed register at scl fall ending read command acknowledge
// (RQ3) read may repeat within a transaction without stop
// (RQ4) host not-acknowledge ends the read and releases sda
// (RQ5) host ends read with not-acknowledge on final byte, then sda released
// (RQ6) device drives acknowledge after each valid address and command byte
// (RQ7) after command error, not-acknowledge every byte until next start
// (RQ8) read after error returns last valid address, not rejected one
// (RQ9) acknowledge general call address and decode its second byte
// (RQ10) second byte with lsb set: ignore everything until stop; the code also stops ignoring at a repeated start
// (RQ11) other general call codes are not acknowledged
// (RQ12) reset code triggers internal reset at its acknowledge
// (RQ13) general call reset does not run the power-on delay
// (RQ14) reset loads default settings into dac registers
// (RQ15) wake-up code clears every channel power-down select bits
// (RQ16) wake-up clear happens at scl fall ending its acknowledge
// (RQ17) general call commands may repeat without stop
// (RQ18) last address kept across stop and repeated start
// (RQ19) host sends control, command, restart, control with read bit
// (RQ20) invalid or unimplemented address not acknowledged; start resets state
// (RQ21) command byte: five-bit address, two-bit op, read is both set
// (RQ22) sda changes only while scl low, data msb first
`timescale 1ns/1ps
module i2rg_target
   import i2rg_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h60
)(
   input  wire logic                  ref_clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  clk_en_i,
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe_o,
   input  wire logic                  wr_en_i,
   input  wire logic [ADDR_W-1:0]     wr_addr_i,
   input  wire logic [DATA_W-1:0]     wr_data_i,
   output logic [NUM_CH*DATA_W-1:0]   dac_o,
   output logic [2*NUM_CH-1:0]        power_down_select_bits_o,
   output logic                       gc_reset_o,
   output logic [ADDR_W-1:0]          last_addr_o
);
   import i2rg_pkg::*;

   i2rg_pins_t pins;
   i2rg_evt_t  evt;

   i2rg_sync i2rg_sync_i (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .clk_en_i  (clk_en_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .pins_o    (pins),
      .evt_o     (evt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state
   i2rg_state_t        state, next_state;
   i2rg_phase_t        phase, next_phase;
   logic [2:0]         bit_cnt, next_bit_cnt;
   logic [7:0]         shreg, next_shreg;
   logic [DATA_W-1:0]  txreg, next_txreg;
   logic               tx_lo, next_tx_lo;
   logic               ackit, next_ackit;
   logic               pend_rd, next_pend_rd;
   logic [1:0]         gc_act, next_gc_act;
   logic               sda_q, next_sda_q;
   logic               oe_q, next_oe_q;
   logic [ADDR_W-1:0]  laddr, next_laddr;
   logic               gcrst, next_gcrst;
   logic [NUM_CH*DATA_W-1:0] dac, next_dac;
   logic [2*NUM_CH-1:0] pds, next_pds;
   logic [DATA_W-1:0]  rd_word;

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a == REG_DAC0) || (a == REG_DAC1) || (a == REG_VREF) ||
                (a == REG_PDN) || (a == REG_GAIN);
   endfunction : addr_ok

   // read mux
   always_comb
   begin
      case (laddr)
         REG_DAC0: rd_word = dac[DATA_W-1:0];
         REG_DAC1: rd_word = dac[2*DATA_W-1:DATA_W];
         REG_PDN:  rd_word = {{(DATA_W-2*NUM_CH){1'b0}}, pds};
         default:  rd_word = ZERO_WORD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus engine
   always_comb
   begin
      next_state   = state;
      next_phase   = phase;
      next_bit_cnt = bit_cnt;
      next_shreg   = shreg;
      next_txreg   = txreg;
      next_tx_lo   = tx_lo;
      next_ackit   = ackit;
      next_pend_rd = pend_rd;
      next_gc_act  = gc_act;
      next_sda_q   = sda_q;
      next_oe_q    = oe_q;
      next_laddr   = laddr;
      next_gcrst   = 1'b0;
      next_dac     = dac;
      next_pds     = pds;
      if (wr_en_i)
      begin
         if (wr_addr_i == REG_DAC0)
            next_dac[DATA_W-1:0] = wr_data_i;
         if (wr_addr_i == REG_DAC1)
            next_dac[2*DATA_W-1:DATA_W] = wr_data_i;
         if (wr_addr_i == REG_PDN)
            next_pds = wr_data_i[2*NUM_CH-1:0];
      end
      // (RQ20) start resets engine
      if (evt.start)
      begin
         next_state   = ST_RXBYT;
         next_phase   = PH_CTRL;
         next_bit_cnt = BIT_FIRST;
         next_oe_q    = 1'b0;
         next_sda_q   = 1'b1;
      end
      else if (evt.stop)
      begin
         // (RQ18) address kept
         next_state   = ST_IDLE;
         next_oe_q    = 1'b0;
         next_pend_rd = 1'b0;
      end
      else
      begin
         case (state)
            ST_RXBYT:
            begin
               if (evt.scl_rise)
               begin
                  next_shreg   = {shreg[6:0], pins.sda};
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == BIT_LAST)
                     next_state = ST_ACK;
               end
            end
            ST_ACK:
            begin
               // decide and drive acknowledge on the fall after the 8th bit
               if (evt.scl_fall && !oe_q)
               begin
                  next_ackit = 1'b0;
                  next_gc_act = 2'b00;
                  case (phase)
                     PH_CTRL:
                     begin
                        if (shreg == GC_ADDR)
                        begin
                           // (RQ9) general call address acked
                           next_ackit = 1'b1;
                           next_phase = PH_GC;
                        end
                        else if (shreg[7:1] == DEV_ADDR)
                        begin
                           next_ackit = 1'b1;
                           next_phase = shreg[0] ? PH_DATA : PH_CMD;
                        end
                     end
                     PH_CMD:
                     begin
                        // (RQ21) decode command byte
                        if (shreg[CMD_OP_HI:CMD_OP_LO] == CMD_OP_READ &&
                            addr_ok(shreg[CMD_ADDR_HI:CMD_ADDR_LO]))
                        begin
                           next_ackit   = 1'b1;
                           next_pend_rd = 1'b1;
                           next_laddr   = shreg[CMD_ADDR_HI:CMD_ADDR_LO];
                        end
                     end
                     PH_GC:
                     begin
                        // (RQ11) only reset and wake codes acked
                        if (shreg == GC_RESET)
                        begin
                           next_ackit  = 1'b1;
                           next_gc_act = 2'b01;
                        end
                        else if (shreg == GC_WAKE)
                        begin
                           next_ackit  = 1'b1;
                           next_gc_act = 2'b10;
                        end
                     end
                     default: next_ackit = 1'b0;
                  endcase
                  if (phase == PH_GC && shreg[0])
                     // (RQ10) hardware call: ignore to next start or stop
                     next_state = ST_IGN;
                  else if (phase == PH_CTRL && !(shreg == GC_ADDR ||
                           shreg[7:1] == DEV_ADDR))
                     next_state = ST_IGN;
                  else if (next_ackit)
                  begin
                     // (RQ6) device acknowledge
                     next_oe_q  = 1'b1;
                     next_sda_q = 1'b0;
                  end
                  else
                     // (RQ7) error: nack until start
                     next_state = ST_NAK;
               end
               else if (evt.scl_fall && oe_q)
               begin
                  next_oe_q    = 1'b0;
                  next_bit_cnt = BIT_FIRST;
                  next_state   = ST_RXBYT;
                  if (phase == PH_DATA)
                  begin
                     // (RQ2) capture at end of acknowledge
                     next_txreg = rd_word;
                     next_tx_lo = 1'b0;
                     next_state = ST_TXBYT;
                     next_oe_q  = ~rd_word[DATA_W-1];
                     next_sda_q = 1'b0;
                     next_bit_cnt = 3'h1;
                  end
                  if (phase == PH_CMD)
                     // (RQ3) read command may be repeated
                     next_phase = PH_CMD;
                  // (RQ12) (RQ13) (RQ14) reset without delay
                  if (gc_act == 2'b01)
                  begin
                     next_gcrst = 1'b1;
                     next_dac   = {NUM_CH{DAC_DEFAULT}};
                     next_pds   = '0;
                  end
                  // (RQ15) (RQ16) wake at ack fall
                  if (gc_act == 2'b10)
                     next_pds = '0;
                  // (RQ17) further general call bytes decoded
                  next_gc_act = 2'b00;
               end
            end
            ST_TXBYT:
            begin
               // (RQ22) shift msb first on scl low
               if (evt.scl_fall)
               begin
                  if (bit_cnt == BIT_FIRST)
                  begin
                     next_oe_q = 1'b0;
                     next_state = ST_MACK;
                  end
                  else
                  begin
                     next_oe_q = ~txreg[{~tx_lo, ~bit_cnt}];
                     next_bit_cnt = bit_cnt + 3'h1;
                  end
               end
            end
            ST_MACK:
            begin
               if (evt.scl_rise)
               begin
                  // (RQ4) (RQ5) host nack ends read
                  if (pins.sda)
                     next_state = ST_IGN;
                  else
                     next_state = ST_MACK;
                  next_ackit = ~pins.sda;
               end
               else if (evt.scl_fall && ackit)
               begin
                  next_tx_lo = ~tx_lo;
                  if (tx_lo)
                     // (RQ8) re-fetch from last valid address
                     next_txreg = rd_word;
                  next_bit_cnt = 3'h1;
                  next_state = ST_TXBYT;
                  next_oe_q  = tx_lo ? ~rd_word[DATA_W-1] : ~txreg[DATA_W/2-1];
               end
            end
            // (RQ1) released until next start
            ST_IGN, ST_NAK, ST_IDLE: next_oe_q = 1'b0;
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state   <= ST_IDLE;
         phase   <= PH_CTRL;
         bit_cnt <= BIT_FIRST;
         shreg   <= 8'h00;
         txreg   <= ZERO_WORD;
         tx_lo   <= 1'b0;
         ackit   <= 1'b0;
         pend_rd <= 1'b0;
         gc_act  <= 2'b00;
         sda_q   <= 1'b1;
         oe_q    <= 1'b0;
         laddr   <= REG_DAC0;
         gcrst   <= 1'b0;
         dac     <= {NUM_CH{DAC_DEFAULT}};
         pds     <= '0;
      end
      else if (clk_en_i)
      begin
         state   <= next_state;
         phase   <= next_phase;
         bit_cnt <= next_bit_cnt;
         shreg   <= next_shreg;
         txreg   <= next_txreg;
         tx_lo   <= next_tx_lo;
         ackit   <= next_ackit;
         pend_rd <= next_pend_rd;
         gc_act  <= next_gc_act;
         sda_q   <= next_sda_q;
         oe_q    <= next_oe_q;
         laddr   <= next_laddr;
         gcrst   <= next_gcrst;
         dac     <= next_dac;
         pds     <= next_pds;
      end
   end

   assign sda_o                    = sda_q;
   assign sda_oe_o                 = oe_q;
   assign dac_o                    = dac;
   assign power_down_select_bits_o = pds;
   assign gc_reset_o               = gcrst;
   assign last_addr_o              = laddr;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_nak_release;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (state == ST_NAK || state == ST_IGN) |-> !sda_oe_o;
   endproperty
   a_nak_release: assert property (p_nak_release) else $error("sda driven while ignoring"); // RQ7

   property p_drive_scl_low;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(sda_oe_o) |-> !pins.scl;
   endproperty
   a_drive_scl_low: assert property (p_drive_scl_low) else $error("sda changed with scl high"); // RQ22

   property p_wake_clear;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == ST_ACK && oe_q && evt.scl_fall && gc_act == 2'b10 && !evt.start
       && !evt.stop) |=> (power_down_select_bits_o == '0);
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear pd bits"); // RQ16

   property p_reset_defaults;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      gc_reset_o |-> (dac_o == {NUM_CH{DAC_DEFAULT}}) && (power_down_select_bits_o == '0);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("reset not defaulted"); // RQ14

   property p_reset_pulse;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (gc_reset_o && clk_en_i) |=> !gc_reset_o;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long"); // RQ13

   property p_addr_kept;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (evt.stop || evt.start) |=> $stable(last_addr_o);
   endproperty
   a_addr_kept: assert property (p_addr_kept) else $error("address lost on stop"); // RQ18

   property p_addr_valid;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(last_addr_o) |-> addr_ok(last_addr_o);
   endproperty
   a_addr_valid: assert property (p_addr_valid) else $error("invalid address kept"); // RQ20

   property p_start_release;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (evt.start && clk_en_i) |=> !sda_oe_o ##1 !sda_oe_o;
   endproperty
   a_start_release: assert property (p_start_release) else $error("sda held after start"); // RQ1

   c_gc_reset: cover property (@(posedge ref_clk_i) gc_reset_o);
   c_read:     cover property (@(posedge ref_clk_i) state == ST_MACK);
   c_nak:      cover property (@(posedge ref_clk_i) state == ST_NAK);
   c_rep_rd:   cover property (@(posedge ref_clk_i) pend_rd && evt.start);

endmodule : i2rg_target

// *** dv/i2rg_host.sv ***
// Purpose: behavioural bus host that drives scl and pulls sda low
// Assumes: sda has a pull-up; bit third is eight system clocks
// Notes:   tasks are called from the bench by hierarchical name
`timescale 1ns/1ps
module i2rg_host
(
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   initial
   begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic q();
      repeat (8) @(posedge ref_clk_i);
      #1;
   endtask : q
   task automatic start();
      sda_oe_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_oe_o = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask : start
   task automatic stop();
      sda_oe_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_oe_o = 1'b0;
      q();
   endtask : stop
   task automatic bit_x(input logic b, output logic got);
      sda_oe_o = ~b;
      q();
      scl_o = 1'b1;
      q();
      got   = sda_i;
      scl_o = 1'b0;
      q();
   endtask : bit_x
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], g);
      bit_x(1'b1, g);
      ack = ~g;
   endtask : wbyte
   task automatic rbyte(output logic [7:0] d, input logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(~ack, g);
   endtask : rbyte
endmodule : i2rg_host

// *** dv/i2c_read_and_general_call_tb.sv ***
// Purpose: self-checking bench for the read and general call target
// Assumes: device address 7'h60; open-drain sda with pull-up
// Notes:   register contents are set through the local write port
`timescale 1ns/1ps
module i2c_read_and_general_call_tb;
   import i2rg_pkg::*;
   localparam logic [7:0] C_W = 8'hc0;
   localparam logic [7:0] C_R = 8'hc1;
   logic                     ref_clk_i, resetn_i, wr_en_i, scl, host_oe;
   logic                     sda_o, sda_oe_o, gc_reset_o, gc_seen;
   logic [ADDR_W-1:0]        wr_addr_i, last_addr_o;
   logic [DATA_W-1:0]        wr_data_i;
   logic [NUM_CH*DATA_W-1:0] dac_o;
   logic [2*NUM_CH-1:0]      pd_o;
   wire                      sda;
   int                       num_errors, n_checks;
   assign sda = (host_oe | (sda_oe_o & ~sda_o)) ? 1'b0 : 1'b1;
   i2rg_target #(.DEV_ADDR(7'h60)) i2rg_target_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .clk_en_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .dac_o(dac_o),
      .power_down_select_bits_o(pd_o), .gc_reset_o(gc_reset_o), .last_addr_o(last_addr_o));
   i2rg_host i2rg_host_i (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i or negedge resetn_i)
      if (!resetn_i)
         gc_seen <= 1'b0;
      else if (gc_reset_o === 1'b1)
         gc_seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk_i);
      #1;
      wr_en_i   = 1'b1;
      wr_addr_i = a;
      wr_data_i = d;
      @(posedge ref_clk_i);
      #1;
      wr_en_i = 1'b0;
   endtask : wreg
   task automatic send(input logic [7:0] d, input logic exp);
      logic a;
      i2rg_host_i.wbyte(d, a);
      chk("ack", {31'h0, exp}, {31'h0, a});
   endtask : send
   task automatic recv(input logic [7:0] exp, input logic ack);
      logic [7:0] d;
      i2rg_host_i.rbyte(d, ack);
      chk("data", {24'h0, exp}, {24'h0, d});
   endtask : recv
   task automatic rd_hdr(input logic [ADDR_W-1:0] a);
      i2rg_host_i.start();
      send(C_W, 1'b1);
      send({a, 3'b110}, 1'b1);
      i2rg_host_i.start();
      send(C_R, 1'b1);
   endtask : rd_hdr
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("dac", 32'h007f_007f, dac_o);
      chk("pd", 32'h0, {28'h0, pd_o});
      chk("last", 32'h0, {27'h0, last_addr_o});
      chk("oe", 32'h0, {31'h0, sda_oe_o});
   endtask : t_reset
   task automatic t_read();
      wreg(REG_DAC1, 16'habcd);
      rd_hdr(REG_DAC1);
      recv(8'hab, 1'b1);
      recv(8'hcd, 1'b0);
      chk("oe", 32'h0, {31'h0, sda_oe_o});
      chk("last", {27'h0, REG_DAC1}, {27'h0, last_addr_o});
      i2rg_host_i.stop();
   endtask : t_read
   task automatic t_cont();
      wreg(REG_DAC0, 16'h1234);
      rd_hdr(REG_DAC0);
      recv(8'h12, 1'b1);
      wreg(REG_DAC0, 16'h5678);
      recv(8'h34, 1'b1);
      recv(8'h56, 1'b1);
      recv(8'h78, 1'b0);
      rd_hdr(REG_DAC1);
      recv(8'hab, 1'b1);
      recv(8'hcd, 1'b0);
      i2rg_host_i.stop();
   endtask : t_cont
   task automatic t_last();
      i2rg_host_i.start();
      send(C_R, 1'b1);
      recv(8'hab, 1'b1);
      recv(8'hcd, 1'b0);
      i2rg_host_i.stop();
   endtask : t_last
   task automatic t_err();
      i2rg_host_i.start();
      send(C_W, 1'b1);
      send({5'h03, 3'b110}, 1'b0);
      send(8'h00, 1'b0);
      i2rg_host_i.start();
      send(C_R, 1'b1);
      recv(8'hab, 1'b1);
      recv(8'hcd, 1'b0);
      i2rg_host_i.start();
      send(C_W, 1'b1);
      send({REG_DAC0, 3'b000}, 1'b0);
      send(C_R, 1'b0);
      chk("last", {27'h0, REG_DAC1}, {27'h0, last_addr_o});
      i2rg_host_i.stop();
   endtask : t_err
   task automatic t_gc();
      wreg(REG_PDN, 16'h00ff);
      wreg(REG_DAC0, 16'h0123);
      chk("pd_set", 32'h1, {31'h0, |pd_o});
      i2rg_host_i.start();
      send(GC_ADDR, 1'b1);
      send(GC_WAKE, 1'b1);
      chk("pd", 32'h0, {28'h0, pd_o});
      send(GC_WAKE, 1'b1);
      send(GC_RESET, 1'b1);
      chk("gc_pulse", 32'h1, {31'h0, gc_seen});
      chk("dac", 32'h007f_007f, dac_o);
      i2rg_host_i.stop();
      i2rg_host_i.start();
      send(GC_ADDR, 1'b1);
      send(8'h04, 1'b0);
      i2rg_host_i.start();
      send(GC_ADDR, 1'b1);
      send(8'h00, 1'b0);
      wreg(REG_PDN, 16'h00ff);
      i2rg_host_i.start();
      send(GC_ADDR, 1'b1);
      send(8'h0b, 1'b0);
      send(GC_WAKE, 1'b0);
      chk("pd_kept", 32'h1, {31'h0, |pd_o});
      i2rg_host_i.stop();
      i2rg_host_i.start();
      send(C_R, 1'b1);
      recv(8'h00, 1'b0);
      i2rg_host_i.stop();
   endtask : t_gc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   initial
   begin
      #2_500_000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      resetn_i   = 1'b0;
      wr_en_i    = 1'b0;
      wr_addr_i  = '0;
      wr_data_i  = '0;
      num_errors = 0;
      n_checks   = 0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      resetn_i = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      t_reset();
      t_read();
      t_cont();
      t_last();
      t_err();
      t_gc();
      print_verdict();
   end
endmodule : i2c_read_and_general_call_tb
